// ---- src/clock_source_startup_control.sv ----
// How it works
// R1 - four-bit source select fuses decode to six oscillator classes, 0001 reserved
// R2 - a fuse bit at one is unprogrammed, at zero programmed
// R3 - factory default: calibrated RC, longest start-up, divide-by-eight programmed
// R4 - internal reset stays asserted a supply time-out after other sources release
// R5 - supply time-out counts 0, 512 or 8192 watchdog oscillator cycles
// R6 - a counter on the selected oscillator holds reset, then releases it
// R7 - oscillator start-up count ranges from 6 to 32K cycles by clock class
// R8 - reset start-up uses time-out plus oscillator count; wake-up from power-down or power-save only the count, from idle or ADC noise reduction none
// R9 - clocks of unused modules halt according to the sleep mode
// R10 - every domain clock runs at the prescaled system clock frequency
// R11 - halting the core clock stops core register and stack logic
// R12 - program memory clock is enabled together with the core clock
// R13 - peripheral clock feeds timers; serial address detection stays asynchronous when halted
// R14 - asynchronous timer clock keeps running during sleep, except in power-down, for real time
// R15 - converter clock runs while core and peripheral clocks are halted
// R16 - level wake from power-down wakes always, interrupts only if level held
// R17 - programmed divide-by-eight fuse divides the system clock by eight
// R18 - domain enables change only while the gated clock is low
module clock_source_startup_control #(
  parameter int TOUT_LONG_CYC = 8192,
  parameter int OSC_LONG_CYC  = 16384,
  parameter int OSC_LF_CYC    = 32768
) (
  input  wire logic                              mclk,
  input  wire logic                              rst,
  input  wire clock_control_pkg::fuse_type       fuse_in,
  input  wire logic                              fuse_valid,
  input  wire logic                              reset_source_active,
  input  wire logic                              wdt_osc,
  input  wire logic                              sel_osc,
  input  wire logic                              sleep_req,
  input  wire clock_control_pkg::sleep_mode_type sleep_mode,
  input  wire logic                              wake_event,
  input  wire logic                              level_irq,
  output logic                                   internal_reset,
  output clock_control_pkg::clk_source_type      clk_source,
  output logic                                   clock_select_reserved,
  output logic                                   sys_clk,
  output clock_control_pkg::domain_clk_type      domain_clk,
  output logic                                   async_detect_armed,
  output logic                                   wake_irq
);

  if (TOUT_LONG_CYC < 1 || TOUT_LONG_CYC > 65536 || OSC_LONG_CYC < 1 ||
      OSC_LONG_CYC > 65536 || OSC_LF_CYC < 1 || OSC_LF_CYC > 65536) begin : g_bad_counts
    $error("cycle count parameters must lie in 1..65536");
  end

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [clock_control_pkg::SYNC_W-1:0] meta_ff;
  logic [clock_control_pkg::SYNC_W-1:0] sync_ff;
  logic [clock_control_pkg::SYNC_W-1:0] raw_in;

  assign raw_in = {level_irq, wake_event, sel_osc, wdt_osc, reset_source_active};

  for (genvar i = 0; i < clock_control_pkg::SYNC_W; i++) begin : g_sync
    always_ff @(posedge mclk or posedge rst) begin
      // reset source reads as asserted until its release is seen
      if (rst) begin
        meta_ff[i] <= (i == clock_control_pkg::SYNC_RST_SRC);
        sync_ff[i] <= (i == clock_control_pkg::SYNC_RST_SRC);
      end else begin
        meta_ff[i] <= raw_in[i];
        sync_ff[i] <= meta_ff[i];
      end
    end
  end

  logic rst_src_s;
  logic wake_s;
  logic level_s;
  logic wdt_prev_ff;
  logic osc_prev_ff;
  logic wdt_tick;
  logic osc_tick;

  assign rst_src_s = sync_ff[clock_control_pkg::SYNC_RST_SRC];
  assign wake_s    = sync_ff[clock_control_pkg::SYNC_WAKE];
  assign level_s   = sync_ff[clock_control_pkg::SYNC_LEVEL_IRQ];
  assign wdt_tick  = sync_ff[clock_control_pkg::SYNC_WDT_OSC] & ~wdt_prev_ff;
  assign osc_tick  = sync_ff[clock_control_pkg::SYNC_SEL_OSC] & ~osc_prev_ff;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wdt_prev_ff <= 1'b0;
      osc_prev_ff <= 1'b0;
    end else begin
      wdt_prev_ff <= sync_ff[clock_control_pkg::SYNC_WDT_OSC];
      osc_prev_ff <= sync_ff[clock_control_pkg::SYNC_SEL_OSC];
    end
  end

  // ----------------------------------------------------------------
  // fuse decode
  // ----------------------------------------------------------------
  localparam int CNT_W_L = clock_control_pkg::CNT_W;

  clock_control_pkg::fuse_type fuse_ff;
  clock_control_pkg::fuse_type nxt_fuse;

  function automatic clock_control_pkg::clk_source_type decode_src(input logic [3:0] sel);
    clock_control_pkg::clk_source_type s;
    s = clock_control_pkg::src_reserved;
    if (sel[3])                 s = clock_control_pkg::src_low_power;   // R1
    else if (sel[3:1] == 3'h3)  s = clock_control_pkg::src_full_swing;  // R1
    else if (sel[3:1] == 3'h2)  s = clock_control_pkg::src_low_freq;    // R1
    else if (sel == 4'h3)       s = clock_control_pkg::src_rc_128k;     // R1
    else if (sel == 4'h2)       s = clock_control_pkg::src_rc_cal;      // R1
    else if (sel == 4'h0)       s = clock_control_pkg::src_external;    // R1
    return s;
  endfunction

  // supply time-out length in watchdog cycles, zero means disabled
  function automatic logic [CNT_W_L:0] tout_len(input clock_control_pkg::fuse_type f);
    logic [CNT_W_L:0] n;
    logic [2:0]       k;
    n = '0;
    k = {f.clock_source_select_fuses[0], f.startup_time_fuses};
    if (f.clock_source_select_fuses[3:1] >= 3'h3) begin
      case (k)
        3'h0, 3'h3, 3'h6: n = (CNT_W_L+1)'(clock_control_pkg::TOUT_SHORT_CYC);
        3'h2, 3'h5:       n = '0;
        default:          n = (CNT_W_L+1)'(TOUT_LONG_CYC);
      endcase
    end else begin
      case (f.startup_time_fuses)
        2'h0:    n = '0;
        2'h1:    n = (CNT_W_L+1)'(clock_control_pkg::TOUT_SHORT_CYC);
        default: n = (CNT_W_L+1)'(TOUT_LONG_CYC);
      endcase
    end
    return n;
  endfunction

  // oscillator start-up length in selected oscillator cycles
  function automatic logic [CNT_W_L:0] osc_len(input clock_control_pkg::fuse_type f);
    logic [CNT_W_L:0] n;
    logic [2:0]       k;
    k = {f.clock_source_select_fuses[0], f.startup_time_fuses};
    case (decode_src(f.clock_source_select_fuses))
      clock_control_pkg::src_low_power,
      clock_control_pkg::src_full_swing: begin
        if (k <= 3'h1)      n = (CNT_W_L+1)'(clock_control_pkg::OSC_SHORT_CYC);
        else if (k <= 3'h4) n = (CNT_W_L+1)'(clock_control_pkg::OSC_MID_CYC);
        else                n = (CNT_W_L+1)'(OSC_LONG_CYC);
      end
      clock_control_pkg::src_low_freq: n = (CNT_W_L+1)'(OSC_LF_CYC);
      clock_control_pkg::src_external: n = (CNT_W_L+1)'(clock_control_pkg::OSC_EXT_CYC);
      default:                         n = (CNT_W_L+1)'(clock_control_pkg::OSC_RC_CYC);
    endcase
    return n;
  endfunction

  logic [CNT_W_L:0] tout_target;
  logic [CNT_W_L:0] osc_target;

  assign tout_target = tout_len(fuse_ff);                                       // R5
  assign osc_target  = osc_len(fuse_ff);                                        // R7

  // ----------------------------------------------------------------
  // start-up sequencer
  // ----------------------------------------------------------------
  clock_control_pkg::startup_state_type state_ff;
  clock_control_pkg::startup_state_type nxt_state;
  clock_control_pkg::sleep_mode_type    mode_ff;
  clock_control_pkg::sleep_mode_type    nxt_mode;
  logic [CNT_W_L:0]                     cnt_ff;
  logic [CNT_W_L:0]                     nxt_cnt;
  logic                                 waking_ff;
  logic                                 nxt_waking;
  logic                                 wake_irq_ff;
  logic                                 nxt_wake_irq;
  logic                                 int_rst_ff;
  logic                                 nxt_int_rst;

  always_comb begin
    nxt_state    = state_ff;
    nxt_mode     = mode_ff;
    nxt_cnt      = cnt_ff;
    nxt_waking   = waking_ff;
    nxt_wake_irq = 1'b0;
    nxt_fuse     = fuse_ff;
    case (state_ff)
      clock_control_pkg::st_hold: begin
        nxt_cnt    = '0;
        nxt_waking = 1'b0;
        if (fuse_valid) nxt_fuse = fuse_in;                                     // R2
        if (!rst_src_s) begin
          nxt_state = (tout_target == '0) ? clock_control_pkg::st_osc_start
                                          : clock_control_pkg::st_timeout;      // R4
        end
      end
      clock_control_pkg::st_timeout: begin
        if (wdt_tick) begin
          nxt_cnt = cnt_ff + 1'b1;                                              // R5
          if (nxt_cnt == tout_target) begin
            nxt_cnt   = '0;
            nxt_state = clock_control_pkg::st_osc_start;                        // R8
          end
        end
      end
      clock_control_pkg::st_osc_start: begin
        if (osc_tick) begin
          nxt_cnt = cnt_ff + 1'b1;                                              // R6
          if (nxt_cnt == osc_target) begin
            nxt_cnt      = '0;
            nxt_state    = clock_control_pkg::st_run;
            nxt_wake_irq = waking_ff & level_s;                                 // R16
            nxt_waking   = 1'b0;
          end
        end
      end
      clock_control_pkg::st_run: begin
        if (sleep_req) begin
          nxt_mode  = sleep_mode;
          nxt_state = clock_control_pkg::st_sleep;
        end
      end
      clock_control_pkg::st_sleep: begin
        if (wake_s) begin
          if (mode_ff == clock_control_pkg::mode_power_down ||
              mode_ff == clock_control_pkg::mode_power_save) begin
            nxt_state  = clock_control_pkg::st_osc_start;                       // R8
            nxt_waking = 1'b1;
            nxt_cnt    = '0;
          end else begin
            nxt_state = clock_control_pkg::st_run;
          end
        end
      end
      default: nxt_state = clock_control_pkg::st_hold;
    endcase
    if (rst_src_s) begin
      nxt_state  = clock_control_pkg::st_hold;
      nxt_waking = 1'b0;
    end
    nxt_int_rst = (nxt_state == clock_control_pkg::st_hold) ||
                  (nxt_state == clock_control_pkg::st_timeout) ||
                  (nxt_state == clock_control_pkg::st_osc_start && !nxt_waking); // R4
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_ff    <= clock_control_pkg::st_hold;
      mode_ff     <= clock_control_pkg::mode_idle;
      cnt_ff      <= '0;
      waking_ff   <= 1'b0;
      wake_irq_ff <= 1'b0;
      int_rst_ff  <= 1'b1;
      fuse_ff     <= clock_control_pkg::FUSE_RESET;                             // R3
    end else begin
      state_ff    <= nxt_state;
      mode_ff     <= nxt_mode;
      cnt_ff      <= nxt_cnt;
      waking_ff   <= nxt_waking;
      wake_irq_ff <= nxt_wake_irq;
      int_rst_ff  <= nxt_int_rst;
      fuse_ff     <= nxt_fuse;
    end
  end

  // ----------------------------------------------------------------
  // prescaler and glitch-free domain gating
  // ----------------------------------------------------------------
  logic [2:0]                        div_ff;
  logic [2:0]                        nxt_div;
  logic                              sys_ff;
  logic                              nxt_sys;
  clock_control_pkg::domain_clk_type en_req;
  clock_control_pkg::domain_clk_type en_ff;
  clock_control_pkg::domain_clk_type nxt_en;
  clock_control_pkg::domain_clk_type dom_ff;
  clock_control_pkg::domain_clk_type nxt_dom;
  logic                              running;
  logic                              sleeping;

  always_comb begin
    nxt_div  = div_ff + 3'h1;
    nxt_sys  = fuse_ff.divide_by_eight_fuse ? nxt_div[0] : nxt_div[2];         // R17
    running  = (state_ff == clock_control_pkg::st_run);
    sleeping = (state_ff == clock_control_pkg::st_sleep);
    en_req.core_clock_domain           = running;                              // R11
    en_req.program_memory_clock_domain = running;                              // R12
    en_req.peripheral_clock_domain     = running ||
      (sleeping && mode_ff == clock_control_pkg::mode_idle);                   // R9
    en_req.converter_clock_domain      = running ||
      (sleeping && mode_ff <= clock_control_pkg::mode_adc_nr);                 // R15
    en_req.async_timer_clock_domain    = !(sleeping &&
      mode_ff == clock_control_pkg::mode_power_down);                          // R14
    nxt_en  = nxt_sys ? en_ff : en_req;                                        // R18
    nxt_dom = {5{nxt_sys}} & nxt_en;                                           // R10
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      div_ff <= clock_control_pkg::DIV_CNT_RESET;
      sys_ff <= 1'b0;
      en_ff  <= '0;
      dom_ff <= '0;
    end else begin
      div_ff <= nxt_div;
      sys_ff <= nxt_sys;
      en_ff  <= nxt_en;
      dom_ff <= nxt_dom;
    end
  end

  assign internal_reset        = int_rst_ff;
  assign clk_source            = decode_src(fuse_ff.clock_source_select_fuses);
  assign clock_select_reserved = (fuse_ff.clock_source_select_fuses ==
                                  clock_control_pkg::SEL_RESERVED);            // R1
  assign sys_clk               = sys_ff;
  assign domain_clk            = dom_ff;
  assign async_detect_armed    = ~en_ff.peripheral_clock_domain;               // R13
  assign wake_irq              = wake_irq_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_decode_rc: assert property (@(posedge mclk) disable iff (rst) // R1
    fuse_ff.clock_source_select_fuses == clock_control_pkg::SEL_RC_CAL
      |-> clk_source == clock_control_pkg::src_rc_cal)
    else $error("calibrated rc code decoded wrongly");
  chk_default_fuse: assert property (@(posedge mclk) disable iff (rst) // R3
    $fell(rst) ##0 !fuse_valid |-> fuse_ff == clock_control_pkg::FUSE_RESET)
    else $error("fuses not at factory default");
  chk_tout_skip: assert property (@(posedge mclk) disable iff (rst) // R4
    $past(state_ff) == clock_control_pkg::st_hold &&
    state_ff == clock_control_pkg::st_osc_start |-> tout_target == '0)
    else $error("time-out skipped while enabled");
  chk_reset_held: assert property (@(posedge mclk) disable iff (rst) // R6
    state_ff == clock_control_pkg::st_timeout ##1
    state_ff == clock_control_pkg::st_osc_start |-> internal_reset)
    else $error("reset released before oscillator count");
  chk_wake_path: assert property (@(posedge mclk) disable iff (rst) // R8
    $past(state_ff) == clock_control_pkg::st_sleep &&
    state_ff == clock_control_pkg::st_osc_start |-> waking_ff && !internal_reset)
    else $error("wake-up took reset path");
  chk_core_halt: assert property (@(posedge mclk) disable iff (rst) // R9
    sleeping [*8] |-> !domain_clk.core_clock_domain)
    else $error("core clock runs in sleep");
  chk_flash_core: assert property (@(posedge mclk) disable iff (rst) // R12
    domain_clk.core_clock_domain == domain_clk.program_memory_clock_domain)
    else $error("program memory clock differs from core clock");
  chk_gate_low: assert property (@(posedge mclk) disable iff (rst) // R18
    $changed(en_ff) |-> !sys_ff)
    else $error("domain enable changed while clock high");
  chk_irq_level: assert property (@(posedge mclk) disable iff (rst) // R16
    wake_irq |-> $past(level_s) && $past(waking_ff))
    else $error("wake interrupt without held level");
  chk_div_eight: assert property (@(posedge mclk) disable iff (rst) // R17
    $rose(sys_ff) && !fuse_ff.divide_by_eight_fuse &&
    !$past(fuse_ff.divide_by_eight_fuse) && !$past(fuse_ff.divide_by_eight_fuse, 2)
      ##1 !fuse_ff.divide_by_eight_fuse [*7] |=> $rose(sys_ff))
    else $error("divided system clock period not eight");

endmodule

// ---- src/clock_control_pkg.sv ----
package clock_control_pkg;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    src_low_power  = 3'h0,
    src_full_swing = 3'h1,
    src_low_freq   = 3'h2,
    src_rc_128k    = 3'h3,
    src_rc_cal     = 3'h4,
    src_external   = 3'h5,
    src_reserved   = 3'h6
  } clk_source_type;

  typedef enum logic [2:0] {
    st_hold      = 3'h0,
    st_timeout   = 3'h1,
    st_osc_start = 3'h2,
    st_run       = 3'h3,
    st_sleep     = 3'h4
  } startup_state_type;

  typedef enum logic [1:0] {
    mode_idle       = 2'h0,
    mode_adc_nr     = 2'h1,
    mode_power_down = 2'h2,
    mode_power_save = 2'h3
  } sleep_mode_type;

  typedef struct packed {
    logic [3:0] clock_source_select_fuses;
    logic [1:0] startup_time_fuses;
    logic       divide_by_eight_fuse;
  } fuse_type;

  typedef struct packed {
    logic core_clock_domain;
    logic peripheral_clock_domain;
    logic program_memory_clock_domain;
    logic async_timer_clock_domain;
    logic converter_clock_domain;
  } domain_clk_type;

  // ----------------------------------------------------------------
  // constants
  // ----------------------------------------------------------------
  localparam fuse_type   FUSE_RESET      = '{4'h2, 2'h2, 1'h0};
  localparam int         CNT_W           = 16;
  localparam logic [3:0] SEL_RESERVED    = 4'h1;
  localparam logic [3:0] SEL_RC_CAL      = 4'h2;
  localparam int         TOUT_SHORT_CYC  = 512;
  localparam int         OSC_EXT_CYC     = 6;
  localparam int         OSC_RC_CYC      = 6;
  localparam int         OSC_SHORT_CYC   = 258;
  localparam int         OSC_MID_CYC     = 1024;
  localparam logic [2:0] DIV_CNT_RESET   = 3'h0;
  localparam int         SYNC_W          = 5;
  localparam int         SYNC_RST_SRC    = 0;
  localparam int         SYNC_WDT_OSC    = 1;
  localparam int         SYNC_SEL_OSC    = 2;
  localparam int         SYNC_WAKE       = 3;
  localparam int         SYNC_LEVEL_IRQ  = 4;

endpackage

// ---- tb/osc_source_model.sv ----
// ----------------------------------------------------------------
// free-running watchdog and selected oscillator, unrelated to mclk
// ----------------------------------------------------------------
module osc_source_model #(
  parameter int WDT_HALF_PS = 78500,
  parameter int SEL_HALF_PS = 51500
) (
  output logic wdt_osc,
  output logic sel_osc
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    wdt_osc = 1'b0;
    #7.3;
    forever #(WDT_HALF_PS * 1ps) wdt_osc = ~wdt_osc;
  end

  initial begin
    sel_osc = 1'b0;
    #3.1;
    forever #(SEL_HALF_PS * 1ps) sel_osc = ~sel_osc;
  end
endmodule

// ---- tb/clock_source_startup_control_tb_top.sv ----
module clock_source_startup_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  localparam int TOUT_L = 8;
  localparam int OSC_L  = 16;
  localparam int OSC_LF = 32;
  logic                              mclk, rst, fuse_valid, reset_source_active;
  logic                              wdt_osc, sel_osc, sleep_req, wake_event, level_irq;
  clock_control_pkg::fuse_type       fuse_in;
  clock_control_pkg::sleep_mode_type sleep_mode;
  logic                              internal_reset, clock_select_reserved, sys_clk;
  logic                              async_detect_armed, wake_irq;
  clock_control_pkg::clk_source_type clk_source;
  clock_control_pkg::domain_clk_type domain_clk;
  int                                failures;
  int                                cmp_count;
  logic [31:0]                       seed;

  osc_source_model osc (.wdt_osc(wdt_osc), .sel_osc(sel_osc));

  clock_source_startup_control #(
    .TOUT_LONG_CYC(TOUT_L), .OSC_LONG_CYC(OSC_L), .OSC_LF_CYC(OSC_LF)
  ) dut (
    .mclk(mclk), .rst(rst), .fuse_in(fuse_in), .fuse_valid(fuse_valid),
    .reset_source_active(reset_source_active), .wdt_osc(wdt_osc), .sel_osc(sel_osc),
    .sleep_req(sleep_req), .sleep_mode(sleep_mode), .wake_event(wake_event),
    .level_irq(level_irq), .internal_reset(internal_reset), .clk_source(clk_source),
    .clock_select_reserved(clock_select_reserved), .sys_clk(sys_clk),
    .domain_clk(domain_clk), .async_detect_armed(async_detect_armed), .wake_irq(wake_irq)
  );

  // ----------------------------------------------------------------
  // expectations
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  function automatic clock_control_pkg::clk_source_type exp_src(logic [3:0] s);
    if (s[3]) return clock_control_pkg::src_low_power;
    if (s[2:1] == 2'h3) return clock_control_pkg::src_full_swing;
    if (s[2:1] == 2'h2) return clock_control_pkg::src_low_freq;
    if (s == 4'h3) return clock_control_pkg::src_rc_128k;
    if (s == 4'h2) return clock_control_pkg::src_rc_cal;
    if (s == 4'h1) return clock_control_pkg::src_reserved;
    return clock_control_pkg::src_external;
  endfunction

  function automatic int exp_tout(clock_control_pkg::fuse_type f);
    logic [2:0] k;
    k = {f.clock_source_select_fuses[0], f.startup_time_fuses};
    if (f.clock_source_select_fuses[3:1] >= 3'h3) begin
      return (k == 3'h0 || k == 3'h3 || k == 3'h6) ? 512 : (k == 3'h2 || k == 3'h5) ? 0 : TOUT_L;
    end
    return (k[1:0] == 2'h0) ? 0 : (k[1:0] == 2'h1) ? 512 : TOUT_L;
  endfunction

  function automatic int exp_osc(clock_control_pkg::fuse_type f);
    logic [2:0] k;
    k = {f.clock_source_select_fuses[0], f.startup_time_fuses};
    if (f.clock_source_select_fuses[3:1] >= 3'h3) return (k <= 1) ? 258 : (k <= 4) ? 1024 : OSC_L;
    if (f.clock_source_select_fuses[3:1] == 3'h2) return OSC_LF;
    return 6;
  endfunction

  // running domains per sleep mode: core, peripheral, program memory, async, converter
  function automatic logic [4:0] exp_dom(int md);
    case (md)
      0: return 5'h0B;
      1: return 5'h03;
      2: return 5'h00;
      default: return 5'h02;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %0h seen %0h", n, e, g);
    end
  endtask

  task automatic test_done();
    if (failures == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic meas(output int per);
    int n;
    for (n = 0; n < 40 && sys_clk !== 1'b0; n++) @(negedge mclk);
    for (n = 0; n < 40 && sys_clk !== 1'b1; n++) @(negedge mclk);
    per = 0;
    do begin @(negedge mclk); per++; end while (sys_clk !== 1'b0 && per < 40);
    do begin @(negedge mclk); per++; end while (sys_clk !== 1'b1 && per < 40);
  endtask

  task automatic startup(clock_control_pkg::fuse_type f, logic v);
    int m;
    int e;
    fuse_in = v ? f : ~f;
    fuse_valid = v;
    reset_source_active = 1'b1;
    rst = 1'b1;
    repeat (10) @(negedge mclk);
    rst = 1'b0;
    repeat (6) @(negedge mclk);
    chk("internal_reset_held", 1, internal_reset);
    reset_source_active = 1'b0;
    for (m = 0; m < 20000 && internal_reset !== 1'b0; m++) @(negedge mclk);
    e = int'(real'(exp_tout(f)) * 6.28 + real'(exp_osc(f)) * 4.12);
    chk("startup_cycles", e, (m >= e - 12 && m <= e + 16) ? e : m);
    meas(m);
    chk("sys_clk_period", f.divide_by_eight_fuse ? 2 : 8, m);
    repeat (8) begin
      @(negedge mclk);
      chk("run_domains", {5{sys_clk}}, domain_clk);
    end
  endtask

  task automatic sleep_case(int md, logic held);
    logic [4:0] seen;
    logic       irq;
    logic       rs;
    int         n;
    sleep_mode = clock_control_pkg::sleep_mode_type'(md[1:0]);
    sleep_req = 1'b1;
    @(negedge mclk);
    sleep_req = 1'b0;
    repeat (10) @(negedge mclk);
    seen = '0;
    repeat (16) begin
      @(negedge mclk);
      seen |= domain_clk;
    end
    chk("sleep_domains", exp_dom(md), seen);
    chk("async_detect_armed", (exp_dom(md) & 5'h08) == 5'h00, async_detect_armed);
    seed = lfsr(seed);
    repeat (seed[2:0]) @(negedge mclk);
    level_irq = (md >= 2);
    wake_event = 1'b1;
    irq = 1'b0;
    rs = 1'b0;
    for (n = 0; n < 400 && domain_clk.core_clock_domain !== 1'b1; n++) begin
      @(negedge mclk);
      if (n == 5 && !held) level_irq = 1'b0;
      irq |= wake_irq;
      rs |= internal_reset;
    end
    wake_event = 1'b0;
    repeat (20) begin
      @(negedge mclk);
      irq |= wake_irq;
    end
    level_irq = 1'b0;
    chk("wake_no_reset", 0, rs);
    chk("wake_latency_ok", 1, (md >= 2) ? (n >= 55 && n <= 100) : (n < 40));
    chk("wake_irq", (md >= 2) && held, irq);
  endtask

  // ----------------------------------------------------------------
  // stimulus
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  initial begin
    #2ms;
    failures++;
    test_done();
  end

  initial begin
    clock_control_pkg::fuse_type cases [4];
    failures = 0;
    cmp_count = 0;
    seed = 32'h00014FD3;
    rst = 1'b1;
    fuse_valid = 1'b0;
    fuse_in = 7'h7F;
    reset_source_active = 1'b1;
    sleep_req = 1'b0;
    sleep_mode = clock_control_pkg::mode_idle;
    wake_event = 1'b0;
    level_irq = 1'b0;
    repeat (10) @(negedge mclk);
    rst = 1'b0;
    repeat (3) @(negedge mclk);
    chk("default_source", clock_control_pkg::src_rc_cal, clk_source);
    fuse_valid = 1'b1;
    for (int i = 0; i < 16; i++) begin
      seed = lfsr(seed);
      fuse_in = {i[3:0], seed[1:0], seed[2]};
      repeat (2) @(negedge mclk);
      chk("clk_source", exp_src(i[3:0]), clk_source);
      chk("reserved_flag", i == 1, clock_select_reserved);
    end
    cases = '{clock_control_pkg::FUSE_RESET, 7'h01, 7'h30, 7'h7F};
    for (int i = 0; i < 4; i++) startup(cases[i], i != 0);
    for (int md = 0; md < 4; md++) sleep_case(md, 1'b1);
    sleep_case(2, 1'b0);
    test_done();
  end
endmodule
